// *** design/flash_mode_cfg.svh ***
// Offsets, reset values, opcodes and timing counts for the flash mode block
`ifndef FLASH_MODE_CFG_SVH
`define FLASH_MODE_CFG_SVH

`define OP_ENTER_FOUR_WIRE 8'h38
`define OP_EXIT_FOUR_WIRE  8'hff
`define OP_RESET_ENABLE    8'h66
`define OP_RESET           8'h99
`define OP_WRITE_ENABLE    8'h06
`define OP_VOL_WRITE_EN    8'h50
`define OP_WRITE_STATUS    8'h01
`define OP_WRITE_DISABLE   8'h04
`define OP_READ_STATUS_1   8'h05
`define OP_READ_STATUS_2   8'h35
`define OP_SUSPEND         8'h75
`define OP_RESUME          8'h7a

`define SR1_BUSY_BIT   0
`define SR1_WEL_BIT    1
`define SR1_GUARD_BIT  7
`define SR2_SUS_BIT    7
`define SR2_QE_BIT     1
`define SR3_PINSEL_BIT 7

// Writable masks of the two status bytes (read-only and reserved bits out)
`define SR1_WR_MASK 8'hfc
`define SR2_WR_MASK 8'h7a
`define SR2_NV_ONLY 8'h38
`define SR_RESET    8'h00
`define SR3_RESET   8'h00

`define CLK_PERIOD_NS   10
`define SW_RESET_NS     10000
`define SW_RESET_CYC    ((`SW_RESET_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HW_RESET_NS     1000
`define HW_RESET_CYC    ((`HW_RESET_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WRITE_STATUS_NS 5000
`define WRITE_STATUS_CYC (`WRITE_STATUS_NS / `CLK_PERIOD_NS)

`endif

// *** design/flash_mode_pkg.sv ***
// Types shared by the flash mode and status block
package flash_mode_pkg;
	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_OPCODE = 2'b01,
		ST_DATA1  = 2'b10,
		ST_DATA2  = 2'b11
	} link_state_e;
endpackage : flash_mode_pkg

// *** design/serial_flash_mode_status_ctrl.sv ***
// Interface mode, pause, resets and status bytes of a serial flash device
// What this block does
// - Opcode 38h enters four-wire mode; opcode then takes two clocks.
// - SPI and four-wire modes are exclusive; opcode FFh returns to SPI.
// - Power-up and software reset leave the device in SPI mode.
// - Four-wire mode is entered only while quad enable is set.
// - In four-wire mode the four pins become data lines 0 to 3.
// - Pause works only in standard or dual SPI with select low.
// - Pause starts at once at pin fall, whatever the clock level.
// - Pause ends at pin rise if clock low, else next clock fall.
// - Paused: outputs float, data inputs and clock ignored, state kept.
// - Opcode 66h then 99h resets; about 10us busy, no commands.
// - Pin function bit picks pause when clear, hardware reset when set.
// - Reset pin low for 1us resets like 66h/99h but without busy, keeps the suspend bit, top priority.
// - With quad enable set the shared pin is only a data line.
// - Write-enable latch set only by 06h, cleared when operation ends.
// - Non-volatile status writes need guard bit, write enable, guard pin.
// - Volatile copies load from non-volatile ones at pin and software reset; power-up clears both.
// - After 50h a status write changes only the volatile copies.
// - Granularity, top/bottom and protect range fields; 000b is none.
// - Guard bit clear ignores guard pin; set lets pin lock status.
// - Busy shows embedded operation; latch shows operation may start.
// - Byte two: suspended 7, complement 6, locks 5..3, quad enable 1.
// - Pin function bit is byte-three bit 7, active only without quad.
// - While busy only read-status is obeyed; busy clears at the end.
`timescale 1ns/100ps
`include "flash_mode_cfg.svh"

module serial_flash_mode_status_ctrl
	import flash_mode_pkg::*;
(
	input  wire logic       clock,
	input  wire logic       reset,
	input  wire logic       link_clock,
	input  wire logic       chip_select_n,
	input  wire logic       data_line_0_in,
	input  wire logic       data_line_1_in,
	input  wire logic       data_line_2_in,
	input  wire logic       data_line_3_in,
	output logic            data_line_1_out,
	output logic            data_line_1_oe_n,
	input  wire logic       pin_function_nv,
	output logic [7:0]      status_byte_one,
	output logic [7:0]      status_byte_two,
	output logic [7:0]      protect_view,
	output logic            four_wire_command_mode,
	output logic            paused,
	output logic            write_guard_pin_view
);

	// Link-side serial engine, clocked on the serial clock except the two core-fed mode views
	logic        chip_select_sync1_q;
	logic        chip_select_sync2_q;
	link_state_e link_state_q;
	logic [7:0]  shift_q;
	logic [3:0]  bit_count_q;
	logic [7:0]  opcode_q;
	logic        opcode_toggle_q;
	logic [7:0]  data_byte_q;
	logic        data_toggle_q;
	logic [15:0] read_shift_q;
	logic        link_four_wire_q;
	logic        link_quad_q;
	logic        link_hold_q;

	// Core-side state
	logic [2:0]  opcode_tog_sync_q;
	logic [2:0]  data_tog_sync_q;
	logic [2:0]  mode_sync_q;
	logic [2:0]  quad_sync_q;
	logic [2:0]  hold_sync_q;
	logic [2:0]  pin3_sync_q;
	logic [2:0]  pin2_sync_q;
	logic [2:0]  cs_core_sync_q;
	logic [7:0]  sr1_nv_q;
	logic [7:0]  sr1_vol_q;
	logic [7:0]  sr2_nv_q;
	logic [7:0]  sr2_vol_q;
	logic        pin_select_q;
	logic        wel_q;
	logic        vol_wen_q;
	logic        busy_q;
	logic        suspended_q;
	logic        four_wire_q;
	logic        reset_armed_q;
	logic [15:0] busy_count_q;
	logic [7:0]  low_count_q;
	logic        hw_reset_q;
	logic        soft_reset_q;
	logic        nv_pending_q;
	logic [7:0]  pend_sr1_q;
	logic [7:0]  pend_sr2_q;
	logic [7:0]  op_core_q;
	logic        op_valid_q;
	logic        data_valid_q;
	logic        writing_q;
	logic        byte2_next_q;
	logic        pause_q;
	logic        guard_q;
	logic        dl1_q;
	logic        dl1_oe_n_q;

	logic        hold_pin_n;
	logic        quad_vol;
	logic        guard_locked;
	logic        any_reset;
	logic        frame_clear;
	logic        hold_active;
	logic        hold_view;
	logic        byte_done;
	logic [7:0]  shift_next;

	assign quad_vol   = sr2_vol_q[`SR2_QE_BIT];
	// Shared pin is only a pause pin without quad and with pause selected
	assign hold_pin_n = data_line_3_in | quad_vol | pin_select_q |
		link_four_wire_q;
	assign any_reset  = reset | hw_reset_q | soft_reset_q;
	// Mode bits settle long before the next frame, so no link register
	assign link_four_wire_q = mode_sync_q[2];
	assign link_quad_q      = quad_sync_q[2];
	// Select high clears the frame even with the serial clock stopped
	assign frame_clear = chip_select_n | reset;
	assign hold_active = link_hold_q & ~hold_pin_n &
		~link_quad_q;
	// Pin rising with clock low ends the pause at once
	assign hold_view = link_hold_q & ~chip_select_n &
		~(hold_pin_n & ~link_clock);
	assign shift_next = link_four_wire_q ?
		{shift_q[3:0], data_line_3_in, data_line_2_in,
		data_line_1_in, data_line_0_in} :
		{shift_q[6:0], data_line_0_in};
	assign byte_done = link_four_wire_q ? (bit_count_q == 4'h1) :
		(bit_count_q == 4'h7);

	// Select is sampled on the serial clock; a dead clock means idle link
	always_ff @(posedge link_clock) begin
		chip_select_sync1_q <= chip_select_n;
		chip_select_sync2_q <= chip_select_sync1_q;
	end

	// Pause taken at once on pin fall; released on the falling clock edge
	always_ff @(negedge link_clock or negedge hold_pin_n) begin
		if (!hold_pin_n) begin
			link_hold_q <= 1'b1;
		end else begin
			link_hold_q <= 1'b0;
		end
	end

	// Frame position; hold freezes everything but keeps state
	always_ff @(posedge link_clock or posedge frame_clear) begin
		if (frame_clear) begin
			link_state_q <= ST_IDLE;
			bit_count_q  <= 4'h0;
			shift_q      <= 8'h00;
		end else if (!hold_active) begin
			shift_q <= shift_next;
			if (byte_done) begin
				bit_count_q <= 4'h0;
				if (link_state_q == ST_DATA1 || link_state_q == ST_DATA2) begin
					link_state_q <= ST_DATA2;
				end else begin
					link_state_q <= ST_DATA1;
				end
			end else begin
				bit_count_q <= bit_count_q + 4'h1;
				if (link_state_q == ST_IDLE) begin
					link_state_q <= ST_OPCODE;
				end
			end
		end
	end

	// Toggles survive deselect so the core never sees a false byte
	always_ff @(posedge link_clock or posedge reset) begin
		if (reset) begin
			opcode_q        <= 8'h00;
			opcode_toggle_q <= 1'b0;
			data_byte_q     <= 8'h00;
			data_toggle_q   <= 1'b0;
		end else if (!chip_select_n && !hold_active && byte_done) begin
			if (link_state_q == ST_DATA1 || link_state_q == ST_DATA2) begin
				data_byte_q   <= shift_next;
				data_toggle_q <= ~data_toggle_q;
			end else begin
				opcode_q        <= shift_next;
				opcode_toggle_q <= ~opcode_toggle_q;
			end
		end
	end

	// Status read data shifts out on the falling edge
	always_ff @(negedge link_clock) begin
		if (chip_select_n || link_state_q == ST_IDLE) begin
			read_shift_q <= {status_byte_one, status_byte_two};
		end else if (!link_hold_q) begin
			read_shift_q <= {read_shift_q[14:0], 1'b0};
		end
	end

	// Crossings into the core clock plus mode views for the link, three stages each
	always_ff @(posedge clock) begin
		opcode_tog_sync_q <= {opcode_tog_sync_q[1:0], opcode_toggle_q};
		data_tog_sync_q   <= {data_tog_sync_q[1:0], data_toggle_q};
		hold_sync_q       <= {hold_sync_q[1:0], hold_view};
		pin3_sync_q       <= {pin3_sync_q[1:0], data_line_3_in};
		pin2_sync_q       <= {pin2_sync_q[1:0], data_line_2_in};
		cs_core_sync_q    <= {cs_core_sync_q[1:0], chip_select_n};
		mode_sync_q       <= {mode_sync_q[1:0], four_wire_q};
		quad_sync_q       <= {quad_sync_q[1:0], quad_vol};
	end

	always_ff @(posedge clock) begin
		op_valid_q   <= opcode_tog_sync_q[2] ^ opcode_tog_sync_q[1];
		data_valid_q <= data_tog_sync_q[2] ^ data_tog_sync_q[1];
		op_core_q    <= opcode_q;
	end

	// Reset pin timing: counts low time only while it is a reset pin
	always_ff @(posedge clock) begin
		if (reset || pin3_sync_q[1] != pin3_sync_q[2] || pin3_sync_q[2] ||
			!pin_select_q || quad_vol) begin
			low_count_q <= 8'h00;
			hw_reset_q  <= 1'b0;
		end else if (low_count_q < 8'(`HW_RESET_CYC)) begin
			low_count_q <= low_count_q + 8'h01;
		end else begin
			hw_reset_q  <= 1'b1;
		end
	end

	// Guard pin counts only without quad mode
	assign guard_locked = sr1_vol_q[`SR1_GUARD_BIT] & ~pin2_sync_q[2] &
		~quad_vol;

	// Command decode and status byte handling
	always_ff @(posedge clock) begin
		soft_reset_q <= 1'b0;
		if (reset) begin
			sr1_nv_q     <= `SR_RESET;
			sr2_nv_q     <= `SR_RESET;
			suspended_q  <= 1'b0;
		end
		if (any_reset) begin
			four_wire_q   <= 1'b0;
			wel_q         <= 1'b0;
			vol_wen_q     <= 1'b0;
			reset_armed_q <= 1'b0;
			writing_q     <= 1'b0;
			byte2_next_q  <= 1'b0;
			nv_pending_q  <= 1'b0;
			busy_q        <= soft_reset_q;
			busy_count_q  <= soft_reset_q ? 16'(`SW_RESET_CYC) : 16'h0000;
			sr1_vol_q     <= reset ? `SR_RESET : sr1_nv_q;
			sr2_vol_q     <= reset ? `SR_RESET : sr2_nv_q;
			if (reset) begin
				pin_select_q <= 1'b0;
			end else begin
				pin_select_q <= pin_function_nv;
			end
		end else if (busy_q) begin
			if (busy_count_q == 16'h0000) begin
				busy_q <= 1'b0;
				wel_q  <= 1'b0;
				if (nv_pending_q) begin
					sr1_nv_q     <= pend_sr1_q;
					sr2_nv_q     <= pend_sr2_q;
					nv_pending_q <= 1'b0;
				end
			end else begin
				busy_count_q <= busy_count_q - 16'h0001;
			end
		end else if (op_valid_q) begin
			reset_armed_q <= (op_core_q == `OP_RESET_ENABLE);
			writing_q     <= 1'b0;
			byte2_next_q  <= 1'b0;
			unique case (op_core_q)
				`OP_ENTER_FOUR_WIRE:
					four_wire_q <= quad_vol;
				`OP_EXIT_FOUR_WIRE:
					four_wire_q <= 1'b0;
				`OP_RESET: begin
					if (reset_armed_q) begin
						soft_reset_q <= 1'b1;
					end
				end
				`OP_WRITE_ENABLE: begin
					wel_q     <= 1'b1;
					vol_wen_q <= 1'b0;
				end
				`OP_VOL_WRITE_EN:
					vol_wen_q <= 1'b1;
				`OP_WRITE_DISABLE: begin
					wel_q     <= 1'b0;
					vol_wen_q <= 1'b0;
				end
				`OP_SUSPEND:
					suspended_q <= 1'b1;
				`OP_RESUME:
					suspended_q <= 1'b0;
				`OP_WRITE_STATUS: begin
					writing_q  <= (wel_q | vol_wen_q) & ~guard_locked;
					pend_sr1_q <= sr1_nv_q;
					pend_sr2_q <= sr2_nv_q;
				end
				default: begin
				end
			endcase
		end else if (data_valid_q && writing_q) begin
			byte2_next_q <= 1'b1;
			if (vol_wen_q) begin
				// Volatile write: non-volatile copies untouched, no busy
				if (!byte2_next_q) begin
					sr1_vol_q <= (data_byte_q & `SR1_WR_MASK) |
						(sr1_vol_q & ~`SR1_WR_MASK);
				end else begin
					sr2_vol_q <= ((data_byte_q & `SR2_WR_MASK & ~`SR2_NV_ONLY)
						| (sr2_vol_q & ~(`SR2_WR_MASK & ~`SR2_NV_ONLY)));
					writing_q <= 1'b0;
					vol_wen_q <= 1'b0;
				end
			end else if (!byte2_next_q) begin
				pend_sr1_q <= (data_byte_q & `SR1_WR_MASK) |
					(sr1_nv_q & ~`SR1_WR_MASK);
				sr1_vol_q  <= (data_byte_q & `SR1_WR_MASK) |
					(sr1_vol_q & ~`SR1_WR_MASK);
			end else begin
				// OTP locks are one-time: can only be set
				pend_sr2_q <= (data_byte_q & `SR2_WR_MASK) |
					(sr2_nv_q & `SR2_NV_ONLY);
				// Left set so the deselect below starts the write cycle
				sr2_vol_q  <= (data_byte_q & `SR2_WR_MASK) |
					(sr2_nv_q & `SR2_NV_ONLY);
			end
		end else if (writing_q && cs_core_sync_q[2] && !vol_wen_q &&
			byte2_next_q) begin
			// Non-volatile write runs as an embedded operation
			writing_q    <= 1'b0;
			nv_pending_q <= 1'b1;
			busy_q       <= 1'b1;
			busy_count_q <= 16'(`WRITE_STATUS_CYC);
		end
	end

	// Outputs registered; pause floats the output line
	always_ff @(posedge clock) begin
		if (reset) begin
			status_byte_one        <= 8'h00;
			status_byte_two        <= 8'h00;
			protect_view           <= 8'h00;
			four_wire_command_mode <= 1'b0;
			paused                 <= 1'b0;
			write_guard_pin_view   <= 1'b0;
			data_line_1_out        <= 1'b0;
			data_line_1_oe_n       <= 1'b1;
		end else begin
			status_byte_one <= {sr1_vol_q[7:2], wel_q, busy_q};
			status_byte_two <= {suspended_q, sr2_vol_q[6:3], 1'b0,
				sr2_vol_q[1], 1'b0};
			// Protect fields: complement, granularity, direction, range
			protect_view <= {1'b0, sr2_vol_q[6], sr1_vol_q[6:2],
				sr1_vol_q[4:2] != 3'b000};
			four_wire_command_mode <= four_wire_q;
			paused                 <= hold_sync_q[2] & ~hw_reset_q;
			write_guard_pin_view   <= guard_locked;
			data_line_1_out        <= read_shift_q[15];
			data_line_1_oe_n       <= cs_core_sync_q[2] |
				hold_sync_q[2];
		end
	end

endmodule : serial_flash_mode_status_ctrl

// *** sim/flash_mode_asserts.sv ***
// Assertion checker for the flash mode and status block
`timescale 1ns/100ps
module flash_mode_asserts
	import flash_mode_pkg::*;
(
	input wire logic       clock,
	input wire logic       reset,
	input wire logic       chip_select_n,
	input wire logic       data_line_1_oe_n,
	input wire logic [7:0] status_byte_one,
	input wire logic [7:0] status_byte_two,
	input wire logic [7:0] protect_view,
	input wire logic       four_wire_command_mode,
	input wire logic       paused
);
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	sequence views_steady;
		($stable(status_byte_one) && $stable(status_byte_two))[*3];
	endsequence
	mode_needs_qe_a: assert property (four_wire_command_mode |-> status_byte_two[1])
		else $error("four-wire mode without quad enable");
	mode_idle_only_a: assert property ($rose(four_wire_command_mode) |-> !status_byte_one[0])
		else $error("mode changed while busy");
	pause_spi_only_a: assert property (paused |-> !four_wire_command_mode && !status_byte_two[1])
		else $error("pause outside standard operation");
	pause_floats_a: assert property (paused[*2] |-> data_line_1_oe_n)
		else $error("output driven during pause");
	deselect_float_a: assert property (chip_select_n[*6] |-> data_line_1_oe_n)
		else $error("output driven while deselected");
	wel_clears_a: assert property ($fell(status_byte_one[0]) |-> ##[0:2] !status_byte_one[1])
		else $error("write enable kept after operation");
	wel_idle_only_a: assert property ($rose(status_byte_one[1]) |-> !status_byte_one[0])
		else $error("write enable set while busy");
	reserved_zero_a: assert property (!status_byte_two[0] && !status_byte_two[2])
		else $error("reserved status bit set");
	protect_map_a: assert property (views_steady |-> protect_view == {1'b0,
		status_byte_two[6], status_byte_one[6:2], |status_byte_one[4:2]})
		else $error("protect view disagrees with status");
endmodule : flash_mode_asserts

bind serial_flash_mode_status_ctrl flash_mode_asserts flash_mode_asserts_i (
	.clock(clock), .reset(reset), .chip_select_n(chip_select_n),
	.data_line_1_oe_n(data_line_1_oe_n), .status_byte_one(status_byte_one),
	.status_byte_two(status_byte_two), .protect_view(protect_view),
	.four_wire_command_mode(four_wire_command_mode), .paused(paused));

// *** sim/spi_host_model.sv ***
// Host bus controller model driving the serial flash link
`timescale 1ns/100ps
module spi_host_model (
	output logic link_clock,
	output logic chip_select_n,
	output logic data_line_0,
	output logic data_line_1,
	output logic data_line_2,
	output logic data_line_3
);
	initial begin
		link_clock = 1'b0;
		chip_select_n = 1'b1;
		data_line_0 = 1'b0;
		data_line_1 = 1'b1;
		data_line_2 = 1'b1;
		data_line_3 = 1'b1;
	end
	// Select is left alone here so a pause never drops the frame
	task pin3(input logic v);
		data_line_3 = v;
	endtask : pin3
	task close;
		#15 chip_select_n = 1'b1;
		// Lines 0 and 1 flip and lines 2 and 3 go high so a stale level can never pass for data
		data_line_0 = ~data_line_0;
		data_line_1 = ~data_line_1;
		data_line_2 = 1'b1;
		data_line_3 = 1'b1;
		#40;
	endtask : close
	// Mode 0: data set while clock low, taken on the rising edge
	task put(input logic [7:0] b, input logic quad, input logic last);
		int i;
		if (chip_select_n) begin
			chip_select_n = 1'b0;
			#20;
		end
		for (i = 7; i >= 0; i = i - (quad ? 4 : 1)) begin
			if (quad)
				{data_line_3, data_line_2, data_line_1, data_line_0} = b[i -: 4];
			else
				data_line_0 = b[i];
			#15 link_clock = 1'b1;
			#15 link_clock = 1'b0;
		end
		if (last)
			close();
	endtask : put
endmodule : spi_host_model

// *** sim/serial_flash_mode_status_ctrl_tb_top.sv ***
// Self-checking bench for the flash mode and status block
`timescale 1ns/100ps
`include "flash_mode_cfg.svh"
module serial_flash_mode_status_ctrl_tb_top;
	import flash_mode_pkg::*;
	logic       clock;
	logic       reset;
	logic       link_clock;
	logic       chip_select_n;
	logic       data_line_0, data_line_1, data_line_2, data_line_3;
	logic       data_line_1_out;
	logic       data_line_1_oe_n;
	logic       pin_function_nv;
	logic [7:0] status_byte_one;
	logic [7:0] status_byte_two;
	logic [7:0] protect_view;
	logic       four_wire_command_mode;
	logic       paused;
	int         n_fail;
	int         checked;

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	serial_flash_mode_status_ctrl serial_flash_mode_status_ctrl_i (
		.clock(clock), .reset(reset), .link_clock(link_clock),
		.chip_select_n(chip_select_n), .data_line_0_in(data_line_0),
		.data_line_1_in(data_line_1), .data_line_2_in(data_line_2),
		.data_line_3_in(data_line_3), .data_line_1_out(data_line_1_out),
		.data_line_1_oe_n(data_line_1_oe_n), .pin_function_nv(pin_function_nv),
		.status_byte_one(status_byte_one), .status_byte_two(status_byte_two),
		.protect_view(protect_view),
		.four_wire_command_mode(four_wire_command_mode), .paused(paused),
		.write_guard_pin_view());

	spi_host_model spi_host_model_i (
		.link_clock(link_clock), .chip_select_n(chip_select_n),
		.data_line_0(data_line_0), .data_line_1(data_line_1),
		.data_line_2(data_line_2), .data_line_3(data_line_3));

	task chk(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : cyc
	task stop_test;
		$display("comparisons %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : stop_test
	task idle_wait;
		int k;
		k = 0;
		while (status_byte_one[0] !== 1'b0 && k < 2000) begin
			cyc(1);
			k++;
		end
		if (k == 2000) begin
			n_fail++;
			stop_test();
		end
	endtask : idle_wait
	task op(input logic [7:0] b, input logic q, input logic last);
		spi_host_model_i.put(b, q, last);
	endtask : op
	// Reset-enable must come straight before reset, then 10us of silence
	task soft_reset(input logic q);
		op(`OP_RESET_ENABLE, q, 1'b1);
		op(`OP_RESET, q, 1'b1);
		cyc(1100);
	endtask : soft_reset
	task wr_status(input logic [7:0] en, input logic [7:0] a,
		input logic [7:0] b);
		op(en, 1'b0, 1'b1);
		op(`OP_WRITE_STATUS, 1'b0, 1'b0);
		op(a, 1'b0, 1'b0);
		op(b, 1'b0, 1'b1);
		cyc(10);
	endtask : wr_status

	initial begin
		n_fail = 0;
		checked = 0;
		reset = 1'b1;
		pin_function_nv = 1'b0;
		repeat (16) @(posedge clock);
		#1 reset = 1'b0;
		cyc(4);
		chk(status_byte_one, 8'h00);
		chk(status_byte_two, 8'h00);
		chk({6'h00, four_wire_command_mode, data_line_1_oe_n}, 8'h01);
		op(`OP_ENTER_FOUR_WIRE, 1'b0, 1'b1);
		cyc(10);
		chk({7'h00, four_wire_command_mode}, 8'h00);
		$display("test reset and refusal finished");
		op(`OP_READ_STATUS_1, 1'b0, 1'b0);
		spi_host_model_i.pin3(1'b0);
		cyc(5);
		chk({6'h00, paused, data_line_1_oe_n}, 8'h03);
		spi_host_model_i.pin3(1'b1);
		cyc(5);
		chk({7'h00, paused}, 8'h00);
		spi_host_model_i.close();
		$display("test pause finished");
		op(`OP_WRITE_ENABLE, 1'b0, 1'b1);
		cyc(10);
		chk(status_byte_one, 8'h02);
		pin_function_nv = 1'b1;
		soft_reset(1'b0);
		chk(status_byte_one, 8'h00);
		op(`OP_WRITE_ENABLE, 1'b0, 1'b1);
		cyc(10);
		// Held well past the 1us minimum at the core clock
		spi_host_model_i.pin3(1'b0);
		cyc(120);
		spi_host_model_i.pin3(1'b1);
		cyc(10);
		chk(status_byte_one, 8'h00);
		$display("test resets finished");
		wr_status(`OP_WRITE_ENABLE, 8'h1c, 8'h42);
		chk({7'h00, status_byte_one[0]}, 8'h01);
		idle_wait();
		chk(status_byte_one, 8'h1c);
		chk(status_byte_two, 8'h42);
		chk(protect_view, 8'h4f);
		$display("test status write finished");
		op(`OP_ENTER_FOUR_WIRE, 1'b0, 1'b1);
		cyc(10);
		chk({7'h00, four_wire_command_mode}, 8'h01);
		op(`OP_EXIT_FOUR_WIRE, 1'b1, 1'b1);
		cyc(10);
		chk({7'h00, four_wire_command_mode}, 8'h00);
		op(`OP_ENTER_FOUR_WIRE, 1'b0, 1'b1);
		cyc(10);
		soft_reset(1'b1);
		chk({7'h00, four_wire_command_mode}, 8'h00);
		$display("test four wire finished");
		wr_status(`OP_VOL_WRITE_EN, 8'h00, 8'h00);
		idle_wait();
		chk(status_byte_one, 8'h00);
		soft_reset(1'b0);
		chk(status_byte_one, 8'h1c);
		chk(status_byte_two, 8'h42);
		$display("test volatile write finished");
		stop_test();
	end
endmodule : serial_flash_mode_status_ctrl_tb_top
